// File: rtl/fsb_pkg.sv
// Shared constants for the flash status word and blank-check engine
package fsb_pkg;
	localparam int STAT_W = 16;
	localparam int BYTE_W = 8;
	localparam int READY_BIT = 7;
	localparam int EPAUSE_BIT = 6;
	localparam int EFAIL_BIT = 5;
	localparam int PFAIL_BIT = 4;
	localparam int PPAUSE_BIT = 2;
	localparam int LOCK_BIT = 1;
	localparam int BANK_BIT = 0;
	localparam logic [STAT_W-1:0] STAT_RESET = 16'h0080;
	localparam int CAP_W = 12;
	localparam logic [CAP_W-1:0] CAP_OFFSET = 12'h555;
	localparam logic [BYTE_W-1:0] CMD_BLANK = 8'h33;
	localparam logic [STAT_W-1:0] ERASED_WORD = 16'hffff;

	typedef enum logic [1:0] {
		FSB_BC_IDLE,
		FSB_BC_ISSUE,
		FSB_BC_WAIT,
		FSB_BC_CHECK
	} fsb_bc_state_t;
endpackage

// File: rtl/fsb_bc_if.sv
// Handshake between the status logic and the blank-check engine
`timescale 1ns/1ps
interface fsb_bc_if #(
	parameter int ADDR_W = 26,
	parameter int SECT_LSB = 16
);
	logic start;
	logic [ADDR_W-SECT_LSB-1:0] sector;
	logic busy;
	logic done;
	logic fail;
	logic [ADDR_W-1:0] addr;
	logic [15:0] rdata;

	modport eng (input start, input sector, input rdata,
		output busy, output done, output fail, output addr);
	modport ctl (output start, output sector, output rdata,
		input busy, input done, input fail, input addr);
endinterface

// File: rtl/fsb_blank_check.sv
// Blank-check engine: walks one sector and stops at the first programmed bit
`timescale 1ns/1ps
module fsb_blank_check
	import fsb_pkg::*;
#(
	parameter int ADDR_W = 26,
	parameter int SECT_LSB = 16,
	parameter int ARRAY_LAT = 2
)(
	input wire logic clk,
	input wire logic rst,
	fsb_bc_if.eng bc
);
	localparam int LAT_W = $clog2(ARRAY_LAT + 1);
	localparam logic [LAT_W-1:0] LAT_LOAD = LAT_W'(ARRAY_LAT - 1);

	typedef struct packed {
		fsb_bc_state_t st;
		logic [ADDR_W-SECT_LSB-1:0] sect;
		logic [SECT_LSB-1:0] idx;
		logic [LAT_W-1:0] lat;
		logic done;
		logic fail;
	} fsb_bc_reg_t;

	fsb_bc_reg_t r;
	fsb_bc_reg_t next_r;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		unique case (r.st)
			FSB_BC_IDLE:
			begin
				if (bc.start)
				begin
					next_r.sect = bc.sector;
					next_r.idx = '0;
					next_r.fail = 1'b0;
					next_r.st = FSB_BC_ISSUE;
				end
			end
			FSB_BC_ISSUE:
			begin
				next_r.lat = LAT_LOAD;
				next_r.st = FSB_BC_WAIT;
			end
			FSB_BC_WAIT:
			begin
				if (r.lat == '0)
					next_r.st = FSB_BC_CHECK;
				else
					next_r.lat = r.lat - 1'b1;
			end
			FSB_BC_CHECK:
			begin
				// Halt at the first word that is not fully erased
				if (bc.rdata != ERASED_WORD) // RULE21
				begin
					next_r.fail = 1'b1;
					next_r.done = 1'b1;
					next_r.st = FSB_BC_IDLE;
				end
				else if (&r.idx)
				begin
					next_r.done = 1'b1;
					next_r.st = FSB_BC_IDLE;
				end
				else
				begin
					next_r.idx = r.idx + 1'b1;
					next_r.st = FSB_BC_ISSUE;
				end
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign bc.busy = (r.st != FSB_BC_IDLE);
	assign bc.done = r.done;
	assign bc.fail = r.fail;
	assign bc.addr = {r.sect, r.idx};

	////////////////////////////////////////////////////////////////////////////
	sequence s_bad_word;
		r.st == FSB_BC_CHECK && bc.rdata != ERASED_WORD;
	endsequence

	a_bc_first_fail: assert property (@(posedge clk) disable iff (rst) // RULE21
		s_bad_word |=> bc.done && bc.fail && r.st == FSB_BC_IDLE ##1 !bc.done)
		else $error("blank check did not stop on first bad word");
endmodule

// File: rtl/fsb_status_top.sv
// Status word, status-read overlay, command filter and blank-check control
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Function
// [RULE1] Keep one 16-bit status word for program and erase sequences.
// [RULE2] After status-read command, only next read in named sector returns status.
// [RULE3] The overlay lasts for exactly one read access, then array data.
// [RULE4] Status can be read with synchronous or asynchronous bus timing.
// [RULE5] A burst read of status repeats the same value until terminated.
// [RULE6] Top eight status bits are don't-care; host ignores them.
// [RULE7] Clear-status zeroes result flags, leaves ready, paused and bank flags.
// [RULE8] Bit 7 reads 1 when nothing programs or erases, else 0.
// [RULE9] Bits 1 to 6 are valid only while bit 7 reads 1.
// [RULE10] Bit 6 shows erase suspended; erase-resume clears it.
// [RULE11] After suspend, host polls until ready before touching same bank.
// [RULE12] Bit 5 holds last erase or blank-check result; clear or reset.
// [RULE13] Bit 4 holds last program result; cleared by clear or reset.
// [RULE14] Bit 2 shows program suspended; program-resume clears it.
// [RULE15] Bit 1 flags a program or erase refused on locked sector.
// [RULE16] Busy: bit 0 is 0 for addressed bank, 1 otherwise; ready: 0.
// [RULE17] Array reads in one bank proceed while another bank is busy.
// [RULE18] Blank check is 33h at first command address, device fully idle.
// [RULE19] Blank check allows no simultaneous operation; array reads are unknown.
// [RULE20] A running blank check shows busy in bits 7 and 0 like erase.
// [RULE21] Blank check halts at first unerased bit, reports, returns idle.
// [RULE22] While programming, only program-suspend and status-read are taken.
// [RULE23] After reset ready reads 1, other defined flags read 0.
////////////////////////////////////////////////////////////////////////////////
module fsb_status_top
	import fsb_pkg::*;
#(
	parameter int ADDR_W = 26,
	parameter int SECT_LSB = 16,
	parameter int BANK_W = 4,
	parameter int ARRAY_LAT = 2,
	parameter logic [7:0] CMD_SREAD = 8'h10,
	parameter logic [7:0] CMD_CLEAR = 8'h11,
	parameter logic [7:0] CMD_PSUSP = 8'h12,
	parameter logic [7:0] CMD_PRESUME = 8'h13,
	parameter logic [7:0] CMD_ESUSP = 8'h14,
	parameter logic [7:0] CMD_ERESUME = 8'h15
)(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic CE_N,
	input wire logic OE_N,
	input wire logic WE_N,
	input wire logic AVD_N,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [STAT_W-1:0] DQ_IN,
	output logic [STAT_W-1:0] DQ_OUT,
	output logic DQ_OE,
	output logic [ADDR_W-1:0] ARRAY_ADDR,
	input wire logic [STAT_W-1:0] ARRAY_RDATA,
	input wire logic ENG_BUSY,
	input wire logic ENG_ERASE,
	input wire logic [BANK_W-1:0] ENG_BANK,
	input wire logic ENG_DONE,
	input wire logic ENG_FAIL,
	input wire logic ENG_LOCKED,
	input wire logic ENG_PAUSED,
	output logic SUSPEND_REQ,
	output logic RESUME_REQ,
	output logic FWD_STB,
	output logic [ADDR_W-1:0] FWD_ADDR,
	output logic [STAT_W-1:0] FWD_DATA
);
	localparam int SECT_W = ADDR_W - SECT_LSB;

	typedef struct packed {
		logic ce_n1, ce_n2, oe_n1, oe_n2, we_n1, we_n2, avd_n1, avd_n2;
		logic we_d, avd_d, rd_d;
		logic [ADDR_W-1:0] addr_s1, addr_s2, addr_lat;
		logic [STAT_W-1:0] dq_s1, dq_s2;
		logic ovl_pend;
		logic [SECT_W-1:0] ovl_sect;
		logic ovl_on;
		logic [STAT_W-1:0] ovl_word;
		logic [STAT_W-1:0] dout;
		logic doe;
		logic [ADDR_W-1:0] arr_addr;
		logic epause, efail, pfail, ppause, lock;
		logic susp, resume, fwd, bc_start;
		logic [SECT_W-1:0] bc_sect;
		logic [ADDR_W-1:0] fwd_addr;
		logic [STAT_W-1:0] fwd_data;
	} fsb_top_reg_t;

	// Pin stages come up idle so no write edge is seen straight after reset
	localparam fsb_top_reg_t TOP_RST = '{ce_n1: 1'b1, ce_n2: 1'b1, oe_n1: 1'b1,
		oe_n2: 1'b1, we_n1: 1'b1, we_n2: 1'b1, avd_n1: 1'b1, avd_n2: 1'b1,
		we_d: 1'b1, avd_d: 1'b1, default: '0};

	fsb_top_reg_t r;
	fsb_top_reg_t next_r;

	fsb_bc_if #(.ADDR_W(ADDR_W), .SECT_LSB(SECT_LSB)) bc ();

	function automatic logic [SECT_W-1:0] sect_of(input logic [ADDR_W-1:0] a);
		sect_of = a[ADDR_W-1:SECT_LSB];
	endfunction

	function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
		bank_of = a[ADDR_W-1 -: BANK_W];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic rd_now;
	logic new_acc;
	logic wr_edge;
	logic ready;
	logic [ADDR_W-1:0] addr_now;
	logic [BANK_W-1:0] busy_bank;
	logic [STAT_W-1:0] status;
	logic [BYTE_W-1:0] code;
	logic cap_hit;

	always_comb
	begin
		rd_now = !r.ce_n2 && !r.oe_n2;
		// A new access is a fresh read enable or a new address in a burst
		new_acc = rd_now && (!r.rd_d || (r.avd_d && !r.avd_n2)); // RULE4
		wr_edge = !r.we_d && r.we_n2 && !r.ce_n2;
		addr_now = !r.avd_n2 ? r.addr_s2 : r.addr_lat;
		code = r.dq_s2[BYTE_W-1:0];
		cap_hit = (r.addr_lat[CAP_W-1:0] == CAP_OFFSET);
		ready = !(ENG_BUSY || bc.busy); // RULE8 RULE20
		busy_bank = bc.busy ? bank_of(bc.addr) : ENG_BANK;
		// Upper byte and the spare bit read zero; host treats them as don't-care
		status = '0; // RULE1 RULE6
		status[READY_BIT] = ready; // RULE8 RULE23
		// Flags are shown even while busy; host discards them then
		status[EPAUSE_BIT] = r.epause; // RULE9 RULE10
		status[EFAIL_BIT] = r.efail; // RULE12
		status[PFAIL_BIT] = r.pfail; // RULE13
		status[PPAUSE_BIT] = r.ppause; // RULE14
		status[LOCK_BIT] = r.lock; // RULE15
		status[BANK_BIT] = !ready && (busy_bank != bank_of(addr_now)); // RULE16 RULE20
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_r = r;
		next_r.ce_n1 = CE_N;
		next_r.ce_n2 = r.ce_n1;
		next_r.oe_n1 = OE_N;
		next_r.oe_n2 = r.oe_n1;
		next_r.we_n1 = WE_N;
		next_r.we_n2 = r.we_n1;
		next_r.avd_n1 = AVD_N;
		next_r.avd_n2 = r.avd_n1;
		next_r.addr_s1 = ADDR;
		next_r.addr_s2 = r.addr_s1;
		next_r.dq_s1 = DQ_IN;
		next_r.dq_s2 = r.dq_s1;
		next_r.we_d = r.we_n2;
		next_r.avd_d = r.avd_n2;
		next_r.rd_d = rd_now;
		next_r.susp = 1'b0;
		next_r.resume = 1'b0;
		next_r.fwd = 1'b0;
		next_r.bc_start = 1'b0;
		if (!r.avd_n2 && !r.ce_n2)
			next_r.addr_lat = r.addr_s2;

		// One overlaid access in the chosen sector; other sectors pass through
		if (new_acc)
		begin
			next_r.ovl_on = r.ovl_pend && (sect_of(addr_now) == r.ovl_sect); // RULE2
			if (next_r.ovl_on)
			begin
				next_r.ovl_word = status;
				next_r.ovl_pend = 1'b0; // RULE3
			end
		end
		else if (!rd_now)
			next_r.ovl_on = 1'b0; // RULE3
		// Word is frozen at access start, so a burst repeats it
		next_r.dout = next_r.ovl_on ? next_r.ovl_word : ARRAY_RDATA; // RULE5
		next_r.doe = rd_now;
		// Bus reads reach any bank unless a blank check owns the array
		next_r.arr_addr = bc.busy ? bc.addr : addr_now; // RULE17 RULE19

		if (wr_edge)
		begin
			if (code == CMD_SREAD)
			begin
				next_r.ovl_pend = 1'b1; // RULE2
				next_r.ovl_sect = sect_of(r.addr_lat);
			end
			else if (bc.busy)
				next_r.fwd = 1'b0; // RULE19
			else if (ENG_BUSY)
			begin
				// Only the matching suspend is taken while a sequence runs
				if (code == (ENG_ERASE ? CMD_ESUSP : CMD_PSUSP)) // RULE22
					next_r.susp = 1'b1;
			end
			else if (code == CMD_CLEAR)
			begin
				next_r.efail = 1'b0; // RULE7
				next_r.pfail = 1'b0;
				next_r.lock = 1'b0;
			end
			else if (code == CMD_PRESUME)
			begin
				next_r.ppause = 1'b0; // RULE14
				next_r.resume = 1'b1;
			end
			else if (code == CMD_ERESUME)
			begin
				next_r.epause = 1'b0; // RULE10
				next_r.resume = 1'b1;
			end
			else if (code == CMD_BLANK)
			begin
				// Refused unless nothing is running or suspended
				if (cap_hit && !r.epause && !r.ppause) // RULE18
				begin
					next_r.bc_start = 1'b1;
					next_r.bc_sect = sect_of(r.addr_lat);
				end
			end
			else
			begin
				next_r.fwd = 1'b1;
				next_r.fwd_addr = r.addr_lat;
				next_r.fwd_data = r.dq_s2;
			end
		end

		// Hardware events come last so they win over a clear in the same cycle
		if (ENG_PAUSED)
		begin
			if (ENG_ERASE)
				next_r.epause = 1'b1; // RULE10
			else
				next_r.ppause = 1'b1; // RULE14
		end
		if (ENG_DONE)
		begin
			if (ENG_ERASE)
				next_r.efail = ENG_FAIL; // RULE12
			else
				next_r.pfail = ENG_FAIL; // RULE13
			next_r.lock = ENG_LOCKED; // RULE15
		end
		if (bc.done)
			next_r.efail = bc.fail; // RULE12 RULE21
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
			r <= TOP_RST; // RULE23
		else
			r <= next_r;
	end

	////////////////////////////////////////////////////////////////////////////
	assign bc.start = r.bc_start;
	assign bc.sector = r.bc_sect;
	assign bc.rdata = ARRAY_RDATA;

	fsb_blank_check #(
		.ADDR_W(ADDR_W),
		.SECT_LSB(SECT_LSB),
		.ARRAY_LAT(ARRAY_LAT)
	) u_blank (
		.clk(MCLK),
		.rst(RST),
		.bc(bc)
	);

	assign DQ_OUT = r.dout;
	assign DQ_OE = r.doe;
	assign ARRAY_ADDR = r.arr_addr;
	assign SUSPEND_REQ = r.susp;
	assign RESUME_REQ = r.resume;
	assign FWD_STB = r.fwd;
	assign FWD_ADDR = r.fwd_addr;
	assign FWD_DATA = r.fwd_data;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	sequence s_sread_cmd;
		wr_edge && code == CMD_SREAD;
	endsequence

	// A pause or completion in the same cycle wins over the clear
	sequence s_clear_cmd;
		wr_edge && code == CMD_CLEAR && ready && !ENG_DONE && !bc.done && !ENG_PAUSED;
	endsequence

	sequence s_ovl_hit;
		r.ovl_pend && new_acc && !wr_edge && sect_of(addr_now) == r.ovl_sect;
	endsequence

	a_reset_flags: assert property ($past(RST) && !ENG_BUSY |-> // RULE23
		status[7:0] == STAT_RESET[7:0])
		else $error("status flags wrong after reset");

	a_clear_results: assert property (s_clear_cmd ##1 !bc.done |-> // RULE7
		!r.efail && !r.pfail && !r.lock && $stable(r.epause) && $stable(r.ppause))
		else $error("clear-status changed wrong flags");

	a_sread_arm: assert property (s_sread_cmd |=> r.ovl_pend) // RULE2
		else $error("status-read did not arm overlay");

	a_overlay_arm: assert property (s_ovl_hit |=> r.ovl_on && !r.ovl_pend) // RULE2
		else $error("status overlay not applied");

	a_overlay_once: assert property (new_acc && !r.ovl_pend |=> !r.ovl_on) // RULE3
		else $error("status overlay outlived one access");

	// Only an access that carries on may be held to the same word
	a_burst_repeat: assert property (r.ovl_on && rd_now && !new_acc |=> // RULE5
		r.ovl_on && $stable(DQ_OUT))
		else $error("burst status word changed");

	a_bank_idle: assert property (ready |-> !status[BANK_BIT] && status[READY_BIT]) // RULE16
		else $error("bank bit set while ready");

	a_prog_filter: assert property (wr_edge && ENG_BUSY && !ENG_ERASE && !bc.busy && // RULE22
		code != CMD_PSUSP |=> !FWD_STB && !RESUME_REQ && !SUSPEND_REQ && !bc.start)
		else $error("command taken during program");

	a_blank_busy: assert property (r.bc_start |=> !ready ##1 !status[READY_BIT]) // RULE20
		else $error("blank check not shown busy");

	a_resume_clear: assert property (wr_edge && ready && code == CMD_ERESUME && // RULE10
		!ENG_PAUSED |=> !r.epause && RESUME_REQ)
		else $error("erase-resume did not clear pause flag");

	a_blank_refused: assert property (wr_edge && ready && code == CMD_BLANK && // RULE18
		!cap_hit |=> !r.bc_start)
		else $error("blank check started off its command address");

	a_program_result: assert property (ENG_DONE && !ENG_ERASE |=> // RULE13 RULE15
		r.pfail == $past(ENG_FAIL) && r.lock == $past(ENG_LOCKED))
		else $error("program result not recorded");

	a_erase_result: assert property (ENG_DONE && ENG_ERASE && !bc.done |=> // RULE12
		r.efail == $past(ENG_FAIL))
		else $error("erase result not recorded");

	a_pause_record: assert property (ENG_PAUSED |=> // RULE10 RULE14
		($past(ENG_ERASE) ? r.epause : r.ppause))
		else $error("suspended state not recorded");
endmodule

// File: verif/fsb_host_model.sv
// Host bus model: asynchronous command writes and pin-level reads
`timescale 1ns/1ps
module fsb_host_model
	import fsb_pkg::*;
#(
	parameter int ADDR_W = 26
)(
	input wire logic MCLK,
	output logic CE_N,
	output logic OE_N,
	output logic WE_N,
	output logic AVD_N,
	output logic [ADDR_W-1:0] ADDR,
	output logic [STAT_W-1:0] DQ_IN,
	input wire logic [STAT_W-1:0] DQ_OUT,
	input wire logic DQ_OE
);
	initial
	begin
		{CE_N, OE_N, WE_N, AVD_N} = 4'hf;
		ADDR = '0;
		DQ_IN = '0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	// Each pin step lasts 4 clocks so the two-flop synchronisers see it
	task automatic write_cmd(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] c);
		{CE_N, AVD_N, WE_N} = 3'h0;
		ADDR = a;
		DQ_IN = {8'h00, c};
		hold(4);
		AVD_N = 1'b1;
		hold(4);
		WE_N = 1'b1;
		hold(4);
		CE_N = 1'b1;
		// Released lines show the inverse so a stale value never passes for data
		ADDR = ~a;
		DQ_IN = ~DQ_IN;
		hold(4);
	endtask
	task automatic read_word(input logic [ADDR_W-1:0] a, output logic [STAT_W-1:0] d,
		output logic ok);
		int k;
		{CE_N, AVD_N} = 2'h0;
		ADDR = a;
		hold(4);
		AVD_N = 1'b1;
		OE_N = 1'b0;
		k = 0;
		while (DQ_OE !== 1'b1 && k < 20)
		begin
			hold(1);
			k++;
		end
		d = DQ_OUT;
		ok = (DQ_OE === 1'b1);
		repeat (4)
		begin
			hold(1);
			if (DQ_OUT !== d)
				ok = 1'b0;
		end
		{CE_N, OE_N} = 2'h3;
		ADDR = ~a;
		hold(5);
	endtask
endmodule

// File: verif/test_fsb_status_top.sv
// Self-checking bench for the status word, its overlay and the blank check
`timescale 1ns/1ps
module test_fsb_status_top
	import fsb_pkg::*;
();
	localparam int AW = 26;
	localparam logic [7:0] C_SREAD = 8'h10, C_CLEAR = 8'h11, C_PSUSP = 8'h12;
	localparam logic [7:0] C_PRESUME = 8'h13, C_ESUSP = 8'h14, C_ERESUME = 8'h15;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce_n, oe_n, we_n, avd_n, dq_oe, susp_req, res_req, fwd_stb, kind;
	logic [AW-1:0] addr, array_addr, sa, sb, ba, fa, fwd_addr;
	logic [7:0] fc;
	logic [STAT_W-1:0] fwd_data;
	logic [AW-1:0] dirty = '1;
	logic [STAT_W-1:0] dq_in, dq_out, array_rdata;
	logic eng_busy = 1'b0, eng_erase = 1'b0, eng_done = 1'b0;
	logic eng_fail = 1'b0, eng_locked = 1'b0, eng_paused = 1'b0;
	logic [3:0] eng_bank = 4'h0;
	logic f_ep = 1'b0, f_ef = 1'b0, f_pf = 1'b0, f_pp = 1'b0, f_lk = 1'b0;
	int err_count = 0, checks_done = 0, cycles = 0, n_susp = 0, n_res = 0, n_fwd = 0, n;
	integer seed = 32'h2e0072e8;

	always #20 mclk = ~mclk;
	// Erased array except one programmed word used to stop a blank check early
	assign array_rdata = (array_addr == dirty) ? 16'hfeff : ERASED_WORD;

	fsb_status_top #(.SECT_LSB(12), .CMD_SREAD(C_SREAD), .CMD_CLEAR(C_CLEAR),
		.CMD_PSUSP(C_PSUSP), .CMD_PRESUME(C_PRESUME), .CMD_ESUSP(C_ESUSP),
		.CMD_ERESUME(C_ERESUME)) u_fsb_status_top (.MCLK(mclk), .RST(rst), .CE_N(ce_n),
		.OE_N(oe_n), .WE_N(we_n), .AVD_N(avd_n), .ADDR(addr), .DQ_IN(dq_in),
		.DQ_OUT(dq_out), .DQ_OE(dq_oe), .ARRAY_ADDR(array_addr), .ARRAY_RDATA(array_rdata),
		.ENG_BUSY(eng_busy), .ENG_ERASE(eng_erase), .ENG_BANK(eng_bank),
		.ENG_DONE(eng_done), .ENG_FAIL(eng_fail), .ENG_LOCKED(eng_locked),
		.ENG_PAUSED(eng_paused), .SUSPEND_REQ(susp_req), .RESUME_REQ(res_req),
		.FWD_STB(fwd_stb), .FWD_ADDR(fwd_addr), .FWD_DATA(fwd_data));

	fsb_host_model #(.ADDR_W(AW)) u_fsb_host_model (.MCLK(mclk), .CE_N(ce_n), .OE_N(oe_n),
		.WE_N(we_n), .AVD_N(avd_n), .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out),
		.DQ_OE(dq_oe));

	always @(posedge mclk)
	begin
		cycles++;
		n_susp += (susp_req === 1'b1);
		n_res += (res_req === 1'b1);
		n_fwd += (fwd_stb === 1'b1);
		if (cycles == 60000)
		begin
			err_count++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmd(input logic [AW-1:0] a, input logic [7:0] c);
		u_fsb_host_model.write_cmd(a, c);
	endtask
	task automatic look(input logic [AW-1:0] a, input logic [15:0] exp, input logic [15:0] m);
		logic [15:0] v;
		logic ok;
		u_fsb_host_model.read_word(a, v, ok);
		check("read word", exp & m, v & m);
		check("burst repeat", 16'h1, {15'h0, ok});
	endtask
	function automatic logic [15:0] word(input logic rdy, input logic b0);
		return {8'h00, rdy, f_ep, f_ef, f_pf, 1'b0, f_pp, f_lk, b0};
	endfunction
	// Upper byte is never compared; while busy only bits 7 and 0 are
	task automatic stat(input logic [AW-1:0] a, input logic rdy, input logic b0);
		cmd(a, C_SREAD);
		look(a, word(rdy, b0), rdy ? 16'h00ff : 16'h0081);
	endtask
	task automatic poll(input logic [AW-1:0] a, output int k);
		logic [15:0] v;
		logic ok;
		k = 0;
		do
		begin
			cmd(a, C_SREAD);
			u_fsb_host_model.read_word(a, v, ok);
			k++;
		end
		while (v[READY_BIT] !== 1'b1 && k < 1000);
	endtask

	initial
	begin
		sa = 26'h0800000 | (26'($random(seed)) & 26'h00ff000);
		sb = sa ^ 26'h1000000;
		ba = {sa[AW-1:12], CAP_OFFSET};
		repeat (2) @(posedge mclk);
		#1;
		rst = 1'b0;
		tick(1);
		stat(sa, 1'b1, 1'b0);
		look(sa, ERASED_WORD, 16'hffff);
		cmd(sa, C_SREAD);
		look(sb, ERASED_WORD, 16'hffff);
		look(sa, word(1'b1, 1'b0), 16'h00ff);
		// Bit 7 set keeps the code clear of every command the block decodes
		n = n_fwd;
		fa = {sb[AW-1:12], 12'($random(seed))};
		fc = 8'($random(seed)) | 8'h80;
		cmd(fa, fc);
		check("forward pulse", 16'(n + 1), 16'(n_fwd));
		check("forward data", {8'h00, fc}, fwd_data);
		check("forward addr lo", fa[15:0], fwd_addr[15:0]);
		check("forward addr hi", 16'(fa[AW-1:16]), 16'(fwd_addr[AW-1:16]));
		repeat (4)
		begin
			kind = 1'($random(seed));
			eng_erase = kind;
			eng_bank = 4'($random(seed));
			eng_busy = 1'b1;
			tick(3);
			{eng_done, eng_fail, eng_locked} = {1'b1, 2'($random(seed))};
			if (kind)
				f_ef = eng_fail;
			else
				f_pf = eng_fail;
			f_lk = eng_locked;
			tick(1);
			{eng_done, eng_busy} = 2'h0;
			stat(sa, 1'b1, 1'b0);
		end
		{eng_busy, eng_erase, eng_bank} = {2'b10, sa[AW-1 -: 4]};
		stat(sa, 1'b0, 1'b0);
		stat(sb, 1'b0, 1'b1);
		look(sb, ERASED_WORD, 16'hffff);
		n = n_fwd + n_res;
		cmd(sa, C_CLEAR);
		cmd(sa, C_ERESUME);
		check("ignored commands", 16'(n), 16'(n_fwd + n_res));
		for (int k = 0; k < 2; k++)
		begin
			{eng_busy, eng_erase} = {1'b1, k[0]};
			n = n_susp;
			cmd(sa, k ? C_ESUSP : C_PSUSP);
			check("suspend pulse", 16'(n + 1), 16'(n_susp));
			{eng_paused, eng_busy} = 2'b10;
			tick(1);
			eng_paused = 1'b0;
			{f_ep, f_pp} = {k[0], ~k[0]};
			poll(sa, n);
			stat(sa, 1'b1, 1'b0);
			cmd(sa, C_CLEAR);
			{f_ef, f_pf, f_lk} = 3'h0;
			stat(sa, 1'b1, 1'b0);
			n = n_res;
			cmd(sa, k ? C_ERESUME : C_PRESUME);
			{f_ep, f_pp} = 2'h0;
			check("resume pulse", 16'(n + 1), 16'(n_res));
			stat(sa, 1'b1, 1'b0);
		end
		// Off its command address the blank check must be refused
		cmd(sa, CMD_BLANK);
		stat(sa, 1'b1, 1'b0);
		// Second pass finds a programmed word early and must end within a few polls
		for (int k = 0; k < 2; k++)
		begin
			dirty = k ? {sa[AW-1:12], 12'h010} : '1;
			cmd(ba, CMD_BLANK);
			stat(ba, 1'b0, 1'b0);
			poll(ba, n);
			check("blank finished", 16'h1, 16'(n < (k ? 8 : 1000)));
			f_ef = k[0];
			stat(ba, 1'b1, 1'b0);
		end
		// Reset after the blank check has finished must drop its error and show ready
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(1);
		f_ef = 1'b0;
		stat(sa, 1'b1, 1'b0);
		give_verdict();
	end
endmodule
